/* irq_vector_ctrl.sv */
`timescale 1ns/1ps

// Behaviour
// R1: sequence-abort request uses offset 0x188, gated by its enable and I, wakes from wait only.
// R2: supply monitor request uses 0x140, enabled by high or low enable, wakes from wait only.
// R3: over-current request uses 0x108, enabled per odd pin, never wakes from stop.
// R4: periodic interrupt uses 0x100, gated by its enable, wakes from stop and wait.
// R5: timer1 channel 0 uses 0x0ac and channel 1 uses 0x0a8, each gated, wake from wait only.
// R6: each vector address is base plus a 15-bit offset; reserved offsets are never issued.
// R7: every reset returns all control state to its reset value.
// R8: on every reset the processor is held until the configuration load finishes, and after power-on reset until the ram init finishes too.
// R9: double-bit faults in the loaded configuration leave protection and security active.
// R10: a reset during a flash command aborts that command at once.
// R11: after power-on reset the ram and its ecc syndromes are initialised.
// R12: other resets leave the ram contents untouched.
// R13: a higher vector offset takes precedence among pending sources.
// R14: software may relocate the vector table through the vector base register.
// R15: a source is presented only when flag and enable are set and I is clear.
module irq_vector_ctrl #(
	parameter int unsigned CFG_WORDS = 8
) (
	input  wire logic                 clk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 por_i,
	input  wire logic                 i_mask_i,
	input  wire logic                 stop_mode_i,
	input  wire logic                 wait_mode_i,
	input  wire irq_vec_pkg::irq_vec_t flags_i,
	input  wire irq_vec_pkg::irq_vec_t enables_i,
	input  wire logic                 base_we_i,
	input  wire logic [14:0]          base_wdata_i,
	input  wire logic                 flash_cmd_busy_i,
	input  wire logic                 cfg_word_valid_i,
	input  wire logic                 cfg_dbl_fault_i,
	output logic                      irq_req_o,
	output logic [14:0]               vec_addr_o,
	output logic [14:0]               vec_base_o,
	output logic                      wake_o,
	output logic                      cpu_hold_o,
	output logic                      secure_o,
	output logic                      flash_abort_o,
	output logic [5:0]                ram_addr_o,
	output logic                      ram_we_o
);

	// ************************************
	// elaboration checks
	// ************************************
	if (CFG_WORDS < 1 || CFG_WORDS > 64) begin : g_bad_cfg_words
		$error("CFG_WORDS out of range");
	end
	if (irq_vec_pkg::VEC_W != 15) begin : g_bad_vec_w
		$error("vector width must be 15");
	end
	if (irq_vec_pkg::RAM_AW != 6) begin : g_bad_ram_aw
		$error("ram address width must be 6");
	end
	if (irq_vec_pkg::N_SRC != 6) begin : g_bad_src
		$error("six vector sources expected");
	end

	// ************************************
	// state
	// ************************************
	irq_vec_pkg::state_t state_r;
	irq_vec_pkg::state_t state_nxt;

	// ************************************
	// source qualification
	// ************************************
	logic        q_abort;
	logic        q_supply;
	logic        q_oc;
	logic        q_per;
	logic        q_t0;
	logic        q_t1;
	logic        any_req;
	logic        wake_any;
	logic [14:0] ofs;

	always_comb begin
		// R15 flag enable mask
		// R1 abort gating
		q_abort  = flags_i.seq_abort & enables_i.seq_abort & ~i_mask_i;
		// R2 either monitor enable
		q_supply = ((flags_i.supply_high & enables_i.supply_high) |
			(flags_i.supply_low & enables_i.supply_low)) & ~i_mask_i;
		// R3 odd pin enables
		q_oc     = |(flags_i.overcurrent & enables_i.overcurrent) & ~i_mask_i;
		// R4 periodic gating
		q_per    = flags_i.periodic & enables_i.periodic & ~i_mask_i;
		// R5 timer channel gating
		q_t0     = flags_i.tim1_ch0 & enables_i.tim1_ch0 & ~i_mask_i;
		q_t1     = flags_i.tim1_ch1 & enables_i.tim1_ch1 & ~i_mask_i;
		any_req  = q_abort | q_supply | q_oc | q_per | q_t0 | q_t1;
		// ************************************
		// priority and wake
		// ************************************
		// R13 highest offset wins
		if (q_abort) begin
			ofs = irq_vec_pkg::OFS_SEQ_ABORT;
		end else if (q_supply) begin
			ofs = irq_vec_pkg::OFS_SUPPLY_MON;
		end else if (q_oc) begin
			ofs = irq_vec_pkg::OFS_OVERCURR;
		end else if (q_per) begin
			ofs = irq_vec_pkg::OFS_PERIODIC;
		end else if (q_t0) begin
			ofs = irq_vec_pkg::OFS_TIM1_CH0;
		end else if (q_t1) begin
			ofs = irq_vec_pkg::OFS_TIM1_CH1;
		end else begin
			ofs = irq_vec_pkg::OFS_NONE;
		end
		// R4 only periodic wakes stop
		wake_any = stop_mode_i & q_per;
		// R5 wait wakes on any source
		wake_any = wake_any | (wait_mode_i & any_req);
	end

	// ************************************
	// next state
	// ************************************
	always_comb begin
		state_nxt = state_r;
		state_nxt.ram_we = 1'b0;
		// R10 abort clears on the first clock after reset
		state_nxt.flash_abort = 1'b0;
		// R14 relocatable base
		if (base_we_i) begin
			state_nxt.vec_base = base_wdata_i;
		end
		state_nxt.irq_req = 1'b0;
		state_nxt.wake = 1'b0;
		// ************************************
		// phase sequencing
		// ************************************
		case (state_r.phase)
			irq_vec_pkg::ST_CFG_LOAD: begin
				// R8 hold until loaded
				state_nxt.cpu_hold = 1'b1;
				if (cfg_word_valid_i) begin
					// R9 double fault secures
					if (cfg_dbl_fault_i) begin
						state_nxt.secure = 1'b1;
					end
					state_nxt.cfg_cnt = state_r.cfg_cnt + 7'h01;
					if (state_r.cfg_cnt == 7'(CFG_WORDS - 1)) begin
						// R11 only cold start clears ram
						if (state_r.cold) begin
							state_nxt.phase = irq_vec_pkg::ST_RAM_INIT;
							state_nxt.ram_we = 1'b1;
						end else begin
							// R12 warm reset skips ram
							state_nxt.phase = irq_vec_pkg::ST_RUN;
							state_nxt.cpu_hold = 1'b0;
						end
					end
				end
			end
			irq_vec_pkg::ST_RAM_INIT: begin
				// R11 sweep ram and syndromes
				if (state_r.ram_addr == irq_vec_pkg::RAM_LAST) begin
					state_nxt.phase = irq_vec_pkg::ST_RUN;
					state_nxt.cpu_hold = 1'b0;
					state_nxt.cold = 1'b0;
				end else begin
					state_nxt.ram_addr = state_r.ram_addr + 6'h01;
					state_nxt.ram_we = 1'b1;
				end
			end
			irq_vec_pkg::ST_RUN: begin
				state_nxt.irq_req = any_req;
				// R6 base plus offset
				state_nxt.vec_addr = 15'(state_nxt.vec_base + ofs);
				state_nxt.wake = wake_any;
			end
			default: begin
				state_nxt.phase = irq_vec_pkg::ST_CFG_LOAD;
			end
		endcase
		// R11 latch power-on cause
		if (por_i) begin
			state_nxt.cold = 1'b1;
		end
	end

	// ************************************
	// state register
	// ************************************
	// R7 reset to defined state
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r.phase       <= irq_vec_pkg::ST_CFG_LOAD;
			state_r.vec_base    <= irq_vec_pkg::BASE_RST;
			state_r.irq_req     <= 1'b0;
			state_r.vec_addr    <= 15'h0000;
			state_r.wake        <= 1'b0;
			state_r.cpu_hold    <= 1'b1;
			state_r.secure      <= 1'b0;
			state_r.flash_abort <= 1'b1;
			state_r.ram_addr    <= 6'h00;
			state_r.ram_we      <= 1'b0;
			state_r.cold        <= 1'b0;
			state_r.cfg_cnt     <= 7'h00;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ************************************
	// outputs
	// ************************************
	assign irq_req_o     = state_r.irq_req;
	assign vec_addr_o    = state_r.vec_addr;
	assign vec_base_o    = state_r.vec_base;
	assign wake_o        = state_r.wake;
	assign cpu_hold_o    = state_r.cpu_hold;
	assign secure_o      = state_r.secure;
	assign flash_abort_o = state_r.flash_abort;
	assign ram_addr_o    = state_r.ram_addr;
	assign ram_we_o      = state_r.ram_we;

endmodule

/* irq_vec_pkg.sv */
package irq_vec_pkg;

	// ************************************
	// vector offsets
	// ************************************
	localparam logic [14:0] OFS_SEQ_ABORT  = 15'h0188;
	localparam logic [14:0] OFS_SUPPLY_MON = 15'h0140;
	localparam logic [14:0] OFS_OVERCURR   = 15'h0108;
	localparam logic [14:0] OFS_PERIODIC   = 15'h0100;
	localparam logic [14:0] OFS_TIM1_CH0   = 15'h00ac;
	localparam logic [14:0] OFS_TIM1_CH1   = 15'h00a8;
	localparam logic [14:0] OFS_NONE       = 15'h0000;

	// ************************************
	// widths and reset values
	// ************************************
	localparam int unsigned VEC_W    = 15;
	localparam int unsigned N_SRC    = 6;
	localparam int unsigned RAM_AW   = 6;
	localparam logic [5:0]  RAM_LAST = 6'h3f;
	localparam logic [14:0] BASE_RST = 15'h0000;

	// ************************************
	// types
	// ************************************
	typedef enum logic [1:0] {
		ST_CFG_LOAD = 2'b00,
		ST_RAM_INIT = 2'b01,
		ST_RUN      = 2'b10
	} phase_t;

	typedef struct packed {
		logic seq_abort;
		logic supply_high;
		logic supply_low;
		logic [3:0] overcurrent;
		logic periodic;
		logic tim1_ch0;
		logic tim1_ch1;
	} irq_vec_t;

	typedef struct packed {
		phase_t      phase;
		logic [14:0] vec_base;
		logic        irq_req;
		logic [14:0] vec_addr;
		logic        wake;
		logic        cpu_hold;
		logic        secure;
		logic        flash_abort;
		logic [5:0]  ram_addr;
		logic        ram_we;
		logic        cold;
		logic [6:0]  cfg_cnt;
	} state_t;

endpackage

/* cpu_fetch_model.sv */
`timescale 1ns/1ps
module cpu_fetch_model (
	input  wire logic        clk_i,
	input  wire logic        irq_req_i,
	input  wire logic        cpu_hold_i,
	input  wire logic [14:0] vec_addr_i,
	output logic      [14:0] fetch_o
);
	always_ff @(posedge clk_i) begin
		if (irq_req_i && !cpu_hold_i) begin
			fetch_o <= vec_addr_i;
		end
	end
endmodule

/* irq_vector_ctrl_sva.sv */
`timescale 1ns/1ps
module irq_vector_ctrl_sva (
	input wire logic                  clk_i,
	input wire logic                  sys_rst_i,
	input wire logic                  i_mask_i,
	input wire logic                  stop_mode_i,
	input wire logic                  wait_mode_i,
	input wire irq_vec_pkg::irq_vec_t flags_i,
	input wire irq_vec_pkg::irq_vec_t enables_i,
	input wire logic                  base_we_i,
	input wire logic [14:0]           base_wdata_i,
	input wire logic                  irq_req_o,
	input wire logic [14:0]           vec_addr_o,
	input wire logic [14:0]           vec_base_o,
	input wire logic                  wake_o,
	input wire logic                  cpu_hold_o,
	input wire logic                  flash_abort_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_mask_blocks: assert property (i_mask_i |=> !irq_req_o) else $error("req while masked");
	a_idle_quiet: assert property (flags_i == '0 |=> !irq_req_o) else $error("req without flag");
	a_hold_quiet: assert property (cpu_hold_o |-> !irq_req_o) else $error("req while held");
	a_hold_reset: assert property ($past(sys_rst_i) |-> cpu_hold_o) else $error("no hold");
	a_abort_pulse: assert property (!$past(sys_rst_i) |-> !flash_abort_o) else $error("abort");
	a_base_write: assert property (base_we_i |=> vec_base_o == $past(base_wdata_i))
		else $error("base not written");
	a_abort_vector: assert property (!cpu_hold_o && !i_mask_i && flags_i.seq_abort
		&& enables_i.seq_abort |=> irq_req_o && vec_addr_o == vec_base_o
		+ irq_vec_pkg::OFS_SEQ_ABORT) else $error("abort vector");
	a_periodic_vec: assert property (!cpu_hold_o && !i_mask_i && flags_i == 10'h004
		&& enables_i.periodic |=> vec_addr_o == vec_base_o + irq_vec_pkg::OFS_PERIODIC)
		else $error("periodic vector");
	a_stop_wake: assert property (stop_mode_i && !wait_mode_i && !flags_i.periodic |=> !wake_o)
		else $error("stop wake");
	a_wait_wake: assert property (wait_mode_i && !cpu_hold_o && !i_mask_i && flags_i.tim1_ch0
		&& enables_i.tim1_ch0 |=> wake_o) else $error("wait wake");
endmodule
bind irq_vector_ctrl irq_vector_ctrl_sva i_sva (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .i_mask_i(i_mask_i),
	.stop_mode_i(stop_mode_i), .wait_mode_i(wait_mode_i),
	.flags_i(flags_i), .enables_i(enables_i),
	.base_we_i(base_we_i), .base_wdata_i(base_wdata_i),
	.irq_req_o(irq_req_o), .vec_addr_o(vec_addr_o), .vec_base_o(vec_base_o),
	.wake_o(wake_o), .cpu_hold_o(cpu_hold_o), .flash_abort_o(flash_abort_o)
);

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 0, sys_rst_i = 1, por_i = 1, i_mask_i = 1, stop_mode_i = 0, wait_mode_i = 0;
	logic base_we_i = 0, flash_cmd_busy_i = 0, cfg_word_valid_i = 0, cfg_dbl_fault_i = 0;
	logic [14:0] base_wdata_i = '0;
	irq_vec_pkg::irq_vec_t flags_i = '0, enables_i = '0;
	logic irq_req_o, wake_o, cpu_hold_o, secure_o, flash_abort_o, ram_we_o;
	logic [14:0] vec_addr_o, vec_base_o, fetch_o;
	logic [5:0] ram_addr_o;
	localparam int CFG_N = 2;
	int n_errors = 0, checked = 0;
	initial forever #2.5 clk_i = ~clk_i;
	irq_vector_ctrl #(.CFG_WORDS(CFG_N)) i_dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_i(por_i),
		.i_mask_i(i_mask_i), .stop_mode_i(stop_mode_i), .wait_mode_i(wait_mode_i),
		.flags_i(flags_i), .enables_i(enables_i),
		.base_we_i(base_we_i), .base_wdata_i(base_wdata_i),
		.flash_cmd_busy_i(flash_cmd_busy_i), .cfg_word_valid_i(cfg_word_valid_i),
		.cfg_dbl_fault_i(cfg_dbl_fault_i), .irq_req_o(irq_req_o),
		.vec_addr_o(vec_addr_o), .vec_base_o(vec_base_o), .wake_o(wake_o),
		.cpu_hold_o(cpu_hold_o), .secure_o(secure_o), .flash_abort_o(flash_abort_o),
		.ram_addr_o(ram_addr_o), .ram_we_o(ram_we_o)
	);
	cpu_fetch_model i_cpu (
		.clk_i(clk_i), .irq_req_i(irq_req_o), .cpu_hold_i(cpu_hold_o),
		.vec_addr_i(vec_addr_o), .fetch_o(fetch_o)
	);
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic boot(input logic cold, input logic flt);
		int w;
		w = 0;
		sys_rst_i = 1;
		por_i = cold;
		tick(2);
		chk(16'(cpu_hold_o), 16'h0001);
		chk(16'(flash_abort_o), 16'h0001);
		chk(16'(vec_base_o), 16'h0000);
		chk(16'({irq_req_o, wake_o, secure_o, ram_we_o, ram_addr_o}), 16'h0000);
		sys_rst_i = 0;
		flash_cmd_busy_i = 0;
		tick(1);
		chk(16'(flash_abort_o), 16'h0000);
		chk(16'(cpu_hold_o), 16'h0001);
		cfg_dbl_fault_i = flt;
		cfg_word_valid_i = 1;
		tick(CFG_N - 1);
		chk(16'(cpu_hold_o), 16'h0001);
		tick(1);
		chk(16'(cpu_hold_o), 16'(cold));
		cfg_word_valid_i = 0;
		cfg_dbl_fault_i = 0;
		por_i = 0;
		for (int i = 0; i < 100 && cpu_hold_o; i++) begin
			if (ram_we_o) chk(16'(ram_addr_o), 16'(w));
			w += ram_we_o;
			tick(1);
		end
		chk(16'(w), cold ? 16'h0040 : 16'h0000);
		chk(16'(secure_o), 16'(flt));
		if (cpu_hold_o !== 1'b0) begin
			n_errors++;
			complete_run;
		end
	endtask
	task automatic vec_tab(input logic [14:0] base);
		logic [14:0] ofs [10];
		ofs = '{irq_vec_pkg::OFS_TIM1_CH1, irq_vec_pkg::OFS_TIM1_CH0, irq_vec_pkg::OFS_PERIODIC,
			irq_vec_pkg::OFS_OVERCURR, irq_vec_pkg::OFS_OVERCURR, irq_vec_pkg::OFS_OVERCURR,
			irq_vec_pkg::OFS_OVERCURR, irq_vec_pkg::OFS_SUPPLY_MON, irq_vec_pkg::OFS_SUPPLY_MON,
			irq_vec_pkg::OFS_SEQ_ABORT};
		base_we_i = 1;
		base_wdata_i = base;
		tick(1);
		base_we_i = 0;
		chk(16'(vec_base_o), {1'b0, base});
		for (int b = 0; b < 10; b++) begin
			flags_i = 10'(1 << b);
			enables_i = '0;
			i_mask_i = 0;
			tick(2);
			chk(16'(irq_req_o), 16'h0000);
			enables_i = flags_i;
			i_mask_i = 1;
			tick(2);
			chk(16'(irq_req_o), 16'h0000);
			i_mask_i = 0;
			stop_mode_i = 1;
			tick(2);
			chk({irq_req_o, vec_addr_o}, {1'b1, base + ofs[b]});
			chk(16'(fetch_o), {1'b0, base + ofs[b]});
			chk(16'(wake_o), 16'(b == 2));
			stop_mode_i = 0;
			wait_mode_i = 1;
			tick(2);
			chk(16'(wake_o), 16'h0001);
			wait_mode_i = 0;
		end
		enables_i = '1;
		flags_i = '0;
		for (int b = 0; b < 10; b++) begin
			flags_i[b] = 1'b1;
			tick(2);
			chk(16'(vec_addr_o), {1'b0, base + ofs[b]});
		end
		flags_i = '0;
	endtask
	initial begin
		boot(1, 0);
		vec_tab(15'h0000);
		vec_tab(15'h6a00);
		flash_cmd_busy_i = 1;
		boot(0, 1);
		vec_tab(15'h1200);
		boot(1, 0);
		complete_run;
	end
endmodule
